//--- design/event_decode.sv
// event number and unit mask decode into a per-cycle counter step
`timescale 1ns/100ps
`include "evsel_cfg.svh"
module event_decode
    import evsel_pkg::*;
(
    // selection and conditions in, step out
    evsel_if.dec bus
);
    function automatic logic legal3(input logic [7:0] m);
        return m == `UM_01 || m == `UM_02 || m == `UM_04;
    endfunction

    function automatic logic pick3(input logic [7:0] m, input logic [2:0] v);
        return (m == `UM_01 && v[0]) || (m == `UM_02 && v[1]) || (m == `UM_04 && v[2]);
    endfunction

    wire logic [7:0] ev_num  = bus.sel.evnum;
    wire logic [7:0] um      = bus.sel.umask;
    wire logic       ev_snp  = ev_num == `EV_SNOOP;
    wire logic       ev_home = ev_num == `EV_HOME_REQ;
    wire logic       ev_full = ev_num == `EV_TRK_FULL;
    wire logic       ev_busy = ev_num == `EV_TRK_BUSY;
    wire logic       ev_occ  = ev_num == `EV_TRK_OCC;
    wire logic       ev_conf = ev_num == `EV_CONFLICT;
    wire logic       ev_ccyc = ev_num == `EV_CONF_CYC;
    wire logic       ev_byp  = ev_num == `EV_BYPASS;
    wire logic       ev_isoc = ev_num == `EV_ISOC_FULL;

    // prior-state qualifier: any selected state matches
    wire logic       qual_hit = |(bus.sel.qual & bus.ev.snoop_prior);
    wire logic [5:0] occ_pick = (um == `UM_01) ? bus.ev.trk_read_occ[5:0] :
                                (um == `UM_02) ? bus.ev.trk_read_occ[11:6] :
                                bus.ev.trk_read_occ[17:12];

    wire logic def_snp  = ev_snp && (um == `UM_02 || um == `UM_04 || um == `UM_08);
    wire logic def_home = ev_home && (legal3(um) || um == `UM_08 || um == `UM_10 || um == `UM_20);
    wire logic def_trk  = (ev_full || ev_busy || ev_occ || ev_ccyc) && legal3(um);
    wire logic def_conf = ev_conf && (um == `UM_02 || um == `UM_04);
    wire logic def_byp  = ev_byp && um == `UM_01;
    wire logic def_isoc = ev_isoc && (legal3(um) || um == `UM_08 || um == `UM_10);

    wire logic hit_snp  = (um == `UM_02 && bus.ev.snoop_to_invalid) ||
                          (um == `UM_04 && bus.ev.snoop_to_shared && qual_hit) ||
                          (um == `UM_08 && bus.ev.snoop_to_invalid && qual_hit);
    wire logic hit_home = |(um[5:0] & bus.ev.home_req);
    wire logic hit_trk  = ev_full ? pick3(um, bus.ev.trk_full) :
                          ev_busy ? pick3(um, bus.ev.trk_busy) :
                          pick3(um, bus.ev.trk_conflict);
    wire logic hit_conf = bus.ev.conflict_dealloc &&
                          ((um == `UM_02 && bus.ev.conflict_peak == `PEAK_TWO) ||
                           (um == `UM_04 && bus.ev.conflict_peak == `PEAK_THREE));
    wire logic hit_byp  = bus.ev.mc_req && bus.ev.mc_bypass &&
                          (bus.ev.mc_local || bus.ev.mc_read);
    wire logic hit_isoc = pick3(um, bus.ev.isoc_full_rd) ||
                          (um == `UM_08 && bus.ev.isoc_full_wr[0]) ||
                          (um == `UM_10 && bus.ev.isoc_full_wr[1]);

    wire logic any_def = def_snp || def_home || def_trk || def_conf || def_byp || def_isoc;
    wire logic hit     = (def_snp && hit_snp) || (def_home && hit_home) ||
                         (def_trk && hit_trk) || (def_conf && hit_conf) ||
                         (def_byp && hit_byp) || (def_isoc && hit_isoc);

    assign bus.defined = any_def;
    // occupancy adds the outstanding read count, all others add one per hit
    assign bus.inc     = !any_def ? 8'h00 :
                         ev_occ ? {2'h0, occ_pick} : {7'h00, hit};
endmodule // event_decode

//--- design/evsel_cfg.svh
// offsets, field positions, reset values and event encodings of the event counter
`ifndef EVSEL_CFG_SVH
`define EVSEL_CFG_SVH

`define OFF_SELECT     12'h000
`define OFF_QUAL       12'h004
`define OFF_COUNT      12'h008
`define OFF_STATUS     12'h00C

`define SEL_EVNUM_LSB  0
`define SEL_UMASK_LSB  8
`define SEL_ENABLE_BIT 22

`define RST_EVNUM      8'h00
`define RST_UMASK      8'h00
`define RST_QUAL       4'h0
`define RST_COUNT      32'h0000_0000

`define EV_SNOOP       8'h0C
`define EV_HOME_REQ    8'h20
`define EV_TRK_FULL    8'h21
`define EV_TRK_BUSY    8'h22
`define EV_TRK_OCC     8'h23
`define EV_CONFLICT    8'h24
`define EV_CONF_CYC    8'h25
`define EV_BYPASS      8'h26
`define EV_ISOC_FULL   8'h28

`define UM_01          8'h01
`define UM_02          8'h02
`define UM_04          8'h04
`define UM_08          8'h08
`define UM_10          8'h10
`define UM_20          8'h20

`define QUAL_MOD       4'h1
`define QUAL_EXCL      4'h2
`define QUAL_SHR       4'h4
`define QUAL_FWD       4'h8

`define PEAK_TWO       2'h2
`define PEAK_THREE     2'h3

`endif

//--- design/evsel_count.sv
// uncore event select and count block with its apb register file
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`include "evsel_cfg.svh"
module evsel_count
    import evsel_pkg::*;
(
    // system
    input  wire logic        clock,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // snoop queue
    input  wire logic        snoop_to_shared,
    input  wire logic        snoop_to_invalid,
    input  wire logic [3:0]  snoop_prior,
    // home logic trackers
    input  wire logic [5:0]  home_req,
    input  wire logic [2:0]  trk_full,
    input  wire logic [2:0]  trk_busy,
    input  wire logic [17:0] trk_read_occ,
    input  wire logic        conflict_dealloc,
    input  wire logic [1:0]  conflict_peak,
    input  wire logic [2:0]  trk_conflict,
    // memory controller
    input  wire logic        mc_req,
    input  wire logic        mc_bypass,
    input  wire logic        mc_local,
    input  wire logic        mc_read,
    input  wire logic [2:0]  isoc_full_rd,
    input  wire logic [1:0]  isoc_full_wr,
    // counter view
    output logic [31:0]      count_value
);
    logic [7:0]  evnum_reg;
    logic [7:0]  umask_reg;
    logic        enable_reg;
    logic [3:0]  qual_reg;
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic [31:0] rdata_reg;

    evsel_if ifc ();

    event_decode u_decode (
        .bus (ifc.dec)
    );

    // selection towards the decoder
    assign ifc.sel.evnum = evnum_reg;
    assign ifc.sel.umask = umask_reg;
    assign ifc.sel.qual  = qual_reg;

    // uncore conditions towards the decoder
    assign ifc.ev.snoop_to_shared  = snoop_to_shared;
    assign ifc.ev.snoop_to_invalid = snoop_to_invalid;
    assign ifc.ev.snoop_prior      = snoop_prior;
    assign ifc.ev.home_req         = home_req;
    assign ifc.ev.trk_full         = trk_full;
    assign ifc.ev.trk_busy         = trk_busy;
    assign ifc.ev.trk_read_occ     = trk_read_occ;
    assign ifc.ev.conflict_dealloc = conflict_dealloc;
    assign ifc.ev.conflict_peak    = conflict_peak;
    assign ifc.ev.trk_conflict     = trk_conflict;
    assign ifc.ev.mc_req           = mc_req;
    assign ifc.ev.mc_bypass        = mc_bypass;
    assign ifc.ev.mc_local         = mc_local;
    assign ifc.ev.mc_read          = mc_read;
    assign ifc.ev.isoc_full_rd     = isoc_full_rd;
    assign ifc.ev.isoc_full_wr     = isoc_full_wr;

    // apb decode
    wire logic        setup      = psel && !penable;
    wire logic        access     = psel && penable;
    wire logic        hit_select = paddr == `OFF_SELECT;
    wire logic        hit_qual   = paddr == `OFF_QUAL;
    wire logic        hit_count  = paddr == `OFF_COUNT;
    wire logic        hit_status = paddr == `OFF_STATUS;
    wire logic        mapped     = hit_select || hit_qual || hit_count || hit_status;
    wire logic        wr_select  = access && pwrite && hit_select;
    wire logic        wr_qual    = access && pwrite && hit_qual;
    wire logic        wr_count   = access && pwrite && hit_count;

    // read words
    wire logic [31:0] select_word = {9'h000, enable_reg, 6'h00, umask_reg, evnum_reg};
    wire logic [31:0] qual_word   = {28'h0000000, qual_reg};
    wire logic [31:0] status_word = {30'h00000000, enable_reg, ifc.defined};
    wire logic [31:0] rd_word     = hit_select ? select_word :
                                    hit_qual   ? qual_word :
                                    hit_count  ? count_reg :
                                    hit_status ? status_word : 32'h0000_0000;

    // the counter only steps on an enabled, defined selection
    wire logic        counting   = enable_reg && ifc.defined;
    wire logic [31:0] step_word  = {24'h000000, ifc.inc};

    // a software write to the counter takes precedence over the step
    assign count_next = wr_count ? pwdata :
                        counting ? count_reg + step_word : count_reg;

    assign pready      = 1'b1;
    assign pslverr     = access && !mapped;
    assign prdata      = rdata_reg;
    assign count_value = count_reg;

    always_ff @(posedge clock) begin
        if (rst) begin
            evnum_reg  <= `RST_EVNUM;
            umask_reg  <= `RST_UMASK;
            enable_reg <= 1'b0;
        end else if (wr_select) begin
            evnum_reg  <= pwdata[`SEL_EVNUM_LSB +: 8];
            umask_reg  <= pwdata[`SEL_UMASK_LSB +: 8];
            enable_reg <= pwdata[`SEL_ENABLE_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            qual_reg <= `RST_QUAL;
        end else if (wr_qual) begin
            qual_reg <= pwdata[3:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            count_reg <= `RST_COUNT;
        end else begin
            count_reg <= count_next;
        end
    end

    // read data is captured in the setup cycle so it stands through the access phase
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (setup) begin
            rdata_reg <= pwrite ? 32'h0000_0000 : rd_word;
        end
    end

    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    function automatic logic sel_is(input logic [7:0] e, input logic [7:0] u);
        return evnum_reg == e && umask_reg == u && enable_reg && !wr_count;
    endfunction

    sequence s_full_run;
        (sel_is(`EV_TRK_FULL, `UM_04) && trk_full[2])[*3];
    endsequence

    sequence s_conflict_run;
        (sel_is(`EV_CONF_CYC, `UM_01) && trk_conflict[0])[*2];
    endsequence

    sequence s_three_added;
        ##1 count_reg == $past(count_reg, 3) + 32'h0000_0003;
    endsequence

    sequence s_two_added;
        ##1 count_reg == $past(count_reg, 2) + 32'h0000_0002;
    endsequence

    chk_snoop_to_inv: assert property (
        sel_is(`EV_SNOOP, `UM_02) && snoop_to_invalid |=> count_reg == $past(count_reg) + 32'h0000_0001)
        else $error("snoop to invalid not counted");

    chk_shared_qual_gate: assert property (
        sel_is(`EV_SNOOP, `UM_04) && snoop_to_shared |=>
            count_reg == $past(count_reg) + {31'h00000000, $past(|(qual_reg & snoop_prior))})
        else $error("shared snoop qualifier gating wrong");

    chk_inv_from_mod: assert property (
        sel_is(`EV_SNOOP, `UM_08) && qual_reg == `QUAL_MOD && snoop_to_invalid &&
        snoop_prior == `QUAL_MOD |=> count_reg == $past(count_reg) + 32'h0000_0001)
        else $error("invalidate from modified not counted");

    chk_local_reads: assert property (
        sel_is(`EV_HOME_REQ, `UM_10) |=>
            count_reg == $past(count_reg) + {31'h00000000, $past(home_req[4])})
        else $error("local read requests miscounted");

    chk_full_cycles: assert property (
        s_full_run |-> s_three_added)
        else $error("tracker full cycles miscounted");

    chk_busy_cycles: assert property (
        sel_is(`EV_TRK_BUSY, `UM_02) |=>
            count_reg == $past(count_reg) + {31'h00000000, $past(trk_busy[1])})
        else $error("tracker busy cycles miscounted");

    chk_read_occupancy: assert property (
        sel_is(`EV_TRK_OCC, `UM_01) |=>
            count_reg == $past(count_reg) + {26'h0000000, $past(trk_read_occ[5:0])})
        else $error("read occupancy not accumulated");

    chk_three_way_peak: assert property (
        sel_is(`EV_CONFLICT, `UM_04) |=> count_reg == $past(count_reg) +
            {31'h00000000, $past(conflict_dealloc && conflict_peak == `PEAK_THREE)})
        else $error("three way conflict miscounted");

    chk_conflict_cycles: assert property (
        s_conflict_run |-> s_two_added)
        else $error("conflict cycles miscounted");

    chk_remote_write_bypass: assert property (
        sel_is(`EV_BYPASS, `UM_01) && mc_req && mc_bypass && !mc_local && !mc_read |=>
            count_reg == $past(count_reg))
        else $error("remote write bypass was counted");

    chk_isoc_write_ch1: assert property (
        sel_is(`EV_ISOC_FULL, `UM_10) |=>
            count_reg == $past(count_reg) + {31'h00000000, $past(isoc_full_wr[1])})
        else $error("isochronous write full miscounted");

    chk_undefined_hold: assert property (
        !ifc.defined && !wr_count |=> count_reg == $past(count_reg))
        else $error("undefined selection moved the counter");

    chk_count_write: assert property (
        wr_count |=> count_reg == $past(pwdata))
        else $error("counter write not taken");

    chk_unmapped_error: assert property (
        access && !mapped |-> pslverr && pready)
        else $error("unmapped access not refused");

    chk_iohub_full: assert property (
        sel_is(`EV_TRK_FULL, `UM_01) |=>
            count_reg == $past(count_reg) + {31'h00000000, $past(trk_full[0])})
        else $error("io hub tracker full cycles miscounted");

    chk_local_busy: assert property (
        sel_is(`EV_TRK_BUSY, `UM_04) |=>
            count_reg == $past(count_reg) + {31'h00000000, $past(trk_busy[2])})
        else $error("local tracker busy cycles miscounted");

    chk_local_occupancy: assert property (
        sel_is(`EV_TRK_OCC, `UM_04) |=>
            count_reg == $past(count_reg) + {26'h0000000, $past(trk_read_occ[17:12])})
        else $error("local read occupancy not accumulated");

    chk_two_way_peak: assert property (
        sel_is(`EV_CONFLICT, `UM_02) |=> count_reg == $past(count_reg) +
            {31'h00000000, $past(conflict_dealloc && conflict_peak == `PEAK_TWO)})
        else $error("two way conflict miscounted");

    chk_local_bypass: assert property (
        sel_is(`EV_BYPASS, `UM_01) && mc_req && mc_bypass && mc_local |=>
            count_reg == $past(count_reg) + 32'h0000_0001)
        else $error("local bypass not counted");

    chk_isoc_read_ch2: assert property (
        sel_is(`EV_ISOC_FULL, `UM_04) |=>
            count_reg == $past(count_reg) + {31'h00000000, $past(isoc_full_rd[2])})
        else $error("isochronous read full miscounted");

    chk_disabled_hold: assert property (
        !enable_reg && !wr_count |=>
            count_reg == $past(count_reg))
        else $error("disabled counter moved");

    chk_remote_reads: assert property (
        sel_is(`EV_HOME_REQ, `UM_04) |=>
            count_reg == $past(count_reg) + {31'h00000000, $past(home_req[2])})
        else $error("remote read requests miscounted");

    chk_local_conflict: assert property (
        sel_is(`EV_CONF_CYC, `UM_04) |=>
            count_reg == $past(count_reg) + {31'h00000000, $past(trk_conflict[2])})
        else $error("local conflict cycles miscounted");

    chk_count_capture: assert property (
        setup && !pwrite && hit_count |=>
            prdata == $past(count_reg))
        else $error("counter read not captured at setup");

    chk_write_rdata_zero: assert property (
        setup && pwrite |=>
            prdata == 32'h0000_0000)
        else $error("read data not cleared on write");

    chk_select_write: assert property (
        wr_select |=> evnum_reg == $past(pwdata[`SEL_EVNUM_LSB +: 8]) &&
            umask_reg == $past(pwdata[`SEL_UMASK_LSB +: 8]) && enable_reg == $past(pwdata[`SEL_ENABLE_BIT]))
        else $error("selection write not taken");
endmodule // evsel_count

//--- design/evsel_if.sv
// selection, event conditions and step between counter and decoder
`timescale 1ns/100ps
interface evsel_if
    import evsel_pkg::*;
();
    evsel_t         sel;
    uncore_events_t ev;
    step_t          inc;
    logic           defined;
    modport ctl (output sel, output ev, input inc, input defined);
    modport dec (input sel, input ev, output inc, output defined);
endinterface

//--- design/evsel_pkg.sv
// types shared by the event counter and its decoder
package evsel_pkg;
    typedef struct packed {
        logic [7:0] evnum;
        logic [7:0] umask;
        logic [3:0] qual;
    } evsel_t;
    typedef struct packed {
        logic        snoop_to_shared;
        logic        snoop_to_invalid;
        logic [3:0]  snoop_prior;
        logic [5:0]  home_req;
        logic [2:0]  trk_full;
        logic [2:0]  trk_busy;
        logic [17:0] trk_read_occ;
        logic        conflict_dealloc;
        logic [1:0]  conflict_peak;
        logic [2:0]  trk_conflict;
        logic        mc_req;
        logic        mc_bypass;
        logic        mc_local;
        logic        mc_read;
        logic [2:0]  isoc_full_rd;
        logic [1:0]  isoc_full_wr;
    } uncore_events_t;
    typedef logic [7:0] step_t;
endpackage

//--- verif/uncore_event_select_counting_test.sv
// self-checking bench of the event select and count block
`timescale 1ns/100ps
module uncore_event_select_counting_test;
    logic        clock, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, count_value, q;
    logic        snoop_to_shared, snoop_to_invalid, conflict_dealloc, mc_req, mc_bypass, mc_local, mc_read, e;
    logic [3:0]  snoop_prior;
    logic [5:0]  home_req;
    logic [2:0]  trk_full, trk_busy, trk_conflict;
    logic [17:0] trk_read_occ;
    logic [1:0]  conflict_peak;
    logic [4:0]  isoc_full;
    int          err_count, n_checks;

    evsel_count u_evsel_count (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .snoop_to_shared(snoop_to_shared), .snoop_to_invalid(snoop_to_invalid), .snoop_prior(snoop_prior),
        .home_req(home_req), .trk_full(trk_full), .trk_busy(trk_busy), .trk_read_occ(trk_read_occ),
        .conflict_dealloc(conflict_dealloc), .conflict_peak(conflict_peak), .trk_conflict(trk_conflict),
        .mc_req(mc_req), .mc_bypass(mc_bypass), .mc_local(mc_local), .mc_read(mc_read),
        .isoc_full_rd(isoc_full[2:0]), .isoc_full_wr(isoc_full[4:3]), .count_value(count_value));
    uncore_status_model u_uncore_status_model (.clock(clock), .snoop_to_shared(snoop_to_shared),
        .snoop_to_invalid(snoop_to_invalid), .snoop_prior(snoop_prior), .home_req(home_req),
        .trk_full(trk_full), .trk_busy(trk_busy), .trk_read_occ(trk_read_occ),
        .conflict_dealloc(conflict_dealloc), .conflict_peak(conflict_peak), .trk_conflict(trk_conflict),
        .mc_req(mc_req), .mc_bypass(mc_bypass), .mc_local(mc_local), .mc_read(mc_read), .isoc_full(isoc_full));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge clock);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (n == 50) begin
            err_count++;
            conclude();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic sel(input logic [7:0] ev, input logic [7:0] um);
        apb(1'b1, 12'h000, {16'h0040, um, ev});
    endtask
    task automatic arm(input logic [7:0] ev, input logic [7:0] um);
        apb(1'b1, 12'h008, 32'h0000_0000);
        sel(ev, um);
    endtask
    task automatic got(input logic [31:0] exp);
        repeat (2) @(posedge clock);
        apb(1'b0, 12'h008, 32'h0);
        check("count", q, exp);
        check("count_value", count_value, exp);
    endtask

    task automatic t_regs();
        apb(1'b0, 12'h000, 32'h0);
        check("select", q, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        check("qual", q, 32'h0);
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        check("unmapped err", {31'h0, e}, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped rd err", {31'h0, e}, 32'h1);
        check("unmapped rd data", q, 32'h0);
        apb(1'b1, 12'h008, 32'h1234_5678);
        apb(1'b0, 12'h008, 32'h0);
        check("count rw", q, 32'h1234_5678);
    endtask
    task automatic t_snoop();
        arm(8'h0C, 8'h02);
        u_uncore_status_model.snoop(1'b0, 1'b1, 4'h1);
        u_uncore_status_model.snoop(1'b0, 1'b1, 4'h8);
        u_uncore_status_model.snoop(1'b1, 1'b0, 4'h2);
        got(32'h2);
        apb(1'b1, 12'h004, 32'h2);
        arm(8'h0C, 8'h04);
        u_uncore_status_model.snoop(1'b1, 1'b0, 4'h2);
        u_uncore_status_model.snoop(1'b1, 1'b0, 4'h1);
        u_uncore_status_model.snoop(1'b0, 1'b1, 4'h2);
        got(32'h1);
        apb(1'b1, 12'h004, 32'h1);
        arm(8'h0C, 8'h08);
        u_uncore_status_model.snoop(1'b0, 1'b1, 4'h1);
        u_uncore_status_model.snoop(1'b0, 1'b1, 4'h4);
        u_uncore_status_model.snoop(1'b1, 1'b0, 4'h1);
        got(32'h1);
    endtask
    task automatic t_home();
        for (int i = 0; i < 6; i++) begin
            arm(8'h20, 8'(1 << i));
            for (int j = 0; j < 6; j++) u_uncore_status_model.hold(0, 18'(1 << j), 1);
            got(32'h1);
        end
    endtask
    task automatic t_levels();
        logic [7:0] evs [3] = '{8'h21, 8'h22, 8'h25};
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 3; i++) begin
                arm(evs[k], 8'(1 << i));
                u_uncore_status_model.hold(k + 1, 18'(7 & ~(1 << i)), 3);
                u_uncore_status_model.hold(k + 1, 18'(1 << i), i + 2);
                got(32'(i + 2));
            end
        end
    endtask
    task automatic t_occ();
        for (int i = 0; i < 3; i++) begin
            arm(8'h23, 8'(1 << i));
            u_uncore_status_model.hold(4, (18'h5 << (6 * i)) | (18'h7 << (6 * ((i + 1) % 3))), 3);
            got(32'h0000_000F);
        end
    endtask
    task automatic t_misc();
        arm(8'h24, 8'h02);
        u_uncore_status_model.conflict(2'h2);
        u_uncore_status_model.conflict(2'h3);
        got(32'h1);
        arm(8'h24, 8'h04);
        u_uncore_status_model.conflict(2'h3);
        u_uncore_status_model.conflict(2'h2);
        got(32'h1);
        arm(8'h26, 8'h01);
        u_uncore_status_model.mc(1'b1, 1'b1, 1'b0);
        u_uncore_status_model.mc(1'b1, 1'b0, 1'b1);
        u_uncore_status_model.mc(1'b1, 1'b0, 1'b0);
        u_uncore_status_model.mc(1'b0, 1'b1, 1'b1);
        got(32'h2);
        for (int i = 0; i < 5; i++) begin
            arm(8'h28, 8'(1 << i));
            u_uncore_status_model.hold(5, 18'(5'h1F & ~(1 << i)), 2);
            u_uncore_status_model.hold(5, 18'(1 << i), 4);
            got(32'h4);
        end
    endtask
    task automatic t_undef();
        arm(8'h20, 8'h03);
        u_uncore_status_model.hold(0, 18'h3F, 2);
        sel(8'h0C, 8'h01);
        u_uncore_status_model.snoop(1'b1, 1'b1, 4'hF);
        sel(8'h21, 8'h08);
        u_uncore_status_model.hold(1, 18'h7, 2);
        sel(8'h27, 8'h01);
        u_uncore_status_model.mc(1'b1, 1'b1, 1'b1);
        apb(1'b1, 12'h000, 32'h0000_020C);
        apb(1'b0, 12'h000, 32'h0);
        check("select rd", q, 32'h0000_020C);
        apb(1'b0, 12'h00C, 32'h0);
        check("status", q, 32'h1);
        u_uncore_status_model.snoop(1'b0, 1'b1, 4'h1);
        got(32'h0);
    endtask

    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 1'b0, 1'b0, 1'b0, 12'h000, 32'h0};
        err_count = 0;
        n_checks  = 0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_snoop();
        t_home();
        t_levels();
        t_occ();
        t_misc();
        t_undef();
        conclude();
    end
endmodule // uncore_event_select_counting_test

//--- verif/uncore_status_model.sv
// partner model producing the snoop, tracker and memory-controller conditions
`timescale 1ns/100ps
module uncore_status_model (
    // clock
    input  wire logic        clock,
    // conditions
    output logic             snoop_to_shared,
    output logic             snoop_to_invalid,
    output logic [3:0]       snoop_prior,
    output logic [5:0]       home_req,
    output logic [2:0]       trk_full,
    output logic [2:0]       trk_busy,
    output logic [17:0]      trk_read_occ,
    output logic             conflict_dealloc,
    output logic [1:0]       conflict_peak,
    output logic [2:0]       trk_conflict,
    output logic             mc_req,
    output logic             mc_bypass,
    output logic             mc_local,
    output logic             mc_read,
    output logic [4:0]       isoc_full
);
    initial begin
        {snoop_to_shared, snoop_to_invalid, snoop_prior, home_req, trk_full, trk_busy} = '0;
        {trk_read_occ, conflict_dealloc, conflict_peak, trk_conflict} = '0;
        {mc_req, mc_bypass, mc_local, mc_read, isoc_full} = '0;
    end
    // prior state is inverted after the pulse and only meaningful with it
    task automatic snoop(input logic shr, input logic inv, input logic [3:0] prior);
        @(posedge clock);
        snoop_to_shared  <= shr;
        snoop_to_invalid <= inv;
        snoop_prior      <= prior;
        @(posedge clock);
        snoop_to_shared  <= 1'b0;
        snoop_to_invalid <= 1'b0;
        snoop_prior      <= ~prior;
    endtask
    task automatic put(input int grp, input logic [17:0] v);
        case (grp)
            0: home_req <= v[5:0];
            1: trk_full <= v[2:0];
            2: trk_busy <= v[2:0];
            3: trk_conflict <= v[2:0];
            4: trk_read_occ <= v;
            default: isoc_full <= v[4:0];
        endcase
    endtask
    task automatic hold(input int grp, input logic [17:0] v, input int n);
        @(posedge clock);
        put(grp, v);
        repeat (n) @(posedge clock);
        put(grp, 18'h0);
    endtask
    task automatic conflict(input logic [1:0] peak);
        @(posedge clock);
        conflict_dealloc <= 1'b1;
        conflict_peak    <= peak;
        @(posedge clock);
        conflict_dealloc <= 1'b0;
        conflict_peak    <= ~peak;
    endtask
    task automatic mc(input logic byp, input logic loc, input logic rd);
        @(posedge clock);
        {mc_req, mc_bypass, mc_local, mc_read} <= {1'b1, byp, loc, rd};
        @(posedge clock);
        {mc_req, mc_bypass, mc_local, mc_read} <= {1'b0, ~byp, ~loc, ~rd};
    endtask
endmodule // uncore_status_model
